/* File: rtl/out_adv_consts.svh */
// Constants for the output stream advancement register bank
// Assumes inclusion by bare name from rtl sources
`ifndef OUT_ADV_CONSTS_SVH
`define OUT_ADV_CONSTS_SVH
`define LOCAL_ADV_FIRST    8'h83
`define LOCAL_ADV_LAST     8'h92
`define BKPL_ADV_FIRST     8'ha3
`define BKPL_ADV_LAST      8'hc2
`define LOCAL_STREAMS      16
`define BKPL_STREAMS       32
`define LOCAL_FAST_STREAMS 8
`define BKPL_FAST_STREAMS  16
`define ADV_CODE_LSB       0
`define ADV_CODE_MSB       1
`define ADV_RESET          2'h0
`define ADV_MAX_CYCLES     6
`define SYS_CLK_KHZ        131072
`endif

/* File: rtl/out_adv_pkg.sv */
// Types for the output stream advancement register bank
// Assumes out_adv_consts.svh is on the include path
package out_adv_pkg;
	typedef logic [1:0] adv_code_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} cpu_req_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} run_state_t;
endpackage

/* File: rtl/output_stream_advancement.sv */
// Output stream advancement register bank and per-stream output advance
// Assumes a synchronous processor port at the internal system clock and
// serial data supplied by the switch core, sampled on that same clock.
//
// Functional notes
// - Sixteen 16-bit local advance registers at consecutive addresses.
// - Thirty-two 16-bit backplane advance registers at consecutive addresses.
// - Local 32 Mbps mode: only local registers 0 to 7 take effect.
// - Backplane 32 Mbps mode: only backplane registers 0 to 15 take effect.
// - Local code sits in bits 1:0, reset zero.
// - Backplane code sits in bits 1:0, reset zero.
// - Lower rates: codes advance 0, 2, 4, 6 system clock cycles.
// - 32 Mbps: codes advance 0, 1, 2, 3 system clock cycles.
// - Advance moves serial output earlier relative to frame boundary.
// - Code zero keeps normal alignment with the output frame pulse.
// - Each register affects only its own stream.
`include "out_adv_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module output_stream_advancement (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire out_adv_pkg::cpu_req_t    cpu_req_i,
	input  wire logic                     local_fast_i,
	input  wire logic                     bkpl_fast_i,
	input  wire logic [15:0]              local_stream_i,
	input  wire logic [31:0]              bkpl_stream_i,
	input  wire logic                     frame_pulse_i,
	output logic      [15:0]              rdata_o,
	output logic                          rd_ack_o,
	output logic      [15:0]              local_serial_out_o,
	output logic      [31:0]              bkpl_serial_out_o,
	output logic                          output_frame_pulse_o
);
	import out_adv_pkg::*;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// The stream data enters through a delay line of ADV_MAX_CYCLES taps;
	// a code of zero reads the deepest tap, aligned with the frame pulse,
	// and larger codes read shallower taps, i.e. earlier.
	localparam int DEPTH = `ADV_MAX_CYCLES;

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Advance in cycles: steps of 2 at lower rates, steps of 1 at 32 Mbps
	function automatic logic [2:0] adv_cycles(input adv_code_t c, input logic fast);
		adv_cycles = fast ? {1'b0, c} : {c, 1'b0};
	endfunction

	wire logic       hit_local = in_range(cpu_req_i.addr, `LOCAL_ADV_FIRST,
		`LOCAL_ADV_LAST);
	wire logic       hit_bkpl  = in_range(cpu_req_i.addr, `BKPL_ADV_FIRST,
		`BKPL_ADV_LAST);
	wire logic [7:0] local_off = cpu_req_i.addr - `LOCAL_ADV_FIRST;
	wire logic [7:0] bkpl_off  = cpu_req_i.addr - `BKPL_ADV_FIRST;
	wire logic [3:0] local_idx = local_off[3:0];
	wire logic [4:0] bkpl_idx  = bkpl_off[4:0];

	adv_code_t local_code [`LOCAL_STREAMS];
	adv_code_t bkpl_code  [`BKPL_STREAMS];

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Bits 15:2 read back as zero; writes to them are discarded
	wire logic [15:0] next_rdata = hit_local ? {14'h0000, local_code[local_idx]} :
		hit_bkpl ? {14'h0000, bkpl_code[bkpl_idx]} : 16'h0000;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o  <= 16'h0000;
			rd_ack_o <= 1'b0;
		end else if (ce_i) begin
			rd_ack_o <= cpu_req_i.rd;
			if (cpu_req_i.rd)
				rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Frame pulse alignment reference
	// ----------------------------------------------------------------
	logic [DEPTH-1:0] fp_line;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fp_line              <= '0;
			output_frame_pulse_o <= 1'b0;
		end else if (ce_i) begin
			fp_line              <= {fp_line[DEPTH-2:0], frame_pulse_i};
			output_frame_pulse_o <= fp_line[DEPTH-1];
		end
	end

	// ----------------------------------------------------------------
	// Local streams
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `LOCAL_STREAMS; gi++) begin : g_local
			logic [DEPTH:0] line;
			wire logic      active = !local_fast_i || (gi < `LOCAL_FAST_STREAMS);
			wire adv_code_t code   = active ? local_code[gi] : `ADV_RESET;
			wire logic [2:0] adv   = adv_cycles(code, local_fast_i);
			wire logic [2:0] tap   = 3'(DEPTH) - adv;
			wire logic       wr_me = ce_i && cpu_req_i.wr && hit_local &&
				(local_idx == 4'(gi));
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					local_code[gi]        <= `ADV_RESET;
					line                  <= '0;
					local_serial_out_o[gi] <= 1'b0;
				end else if (ce_i) begin
					if (wr_me)
						local_code[gi] <= cpu_req_i.wdata[`ADV_CODE_MSB:`ADV_CODE_LSB];
					line <= {line[DEPTH-1:0], local_stream_i[gi]};
					// Same tap for every bit keeps the whole frame shape intact
					local_serial_out_o[gi] <= (tap == 3'd0) ? local_stream_i[gi] :
						line[tap-3'd1];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Backplane streams
	// ----------------------------------------------------------------
	generate
		for (gi = 0; gi < `BKPL_STREAMS; gi++) begin : g_bkpl
			logic [DEPTH:0] line;
			wire logic      active = !bkpl_fast_i || (gi < `BKPL_FAST_STREAMS);
			wire adv_code_t code   = active ? bkpl_code[gi] : `ADV_RESET;
			wire logic [2:0] adv   = adv_cycles(code, bkpl_fast_i);
			wire logic [2:0] tap   = 3'(DEPTH) - adv;
			wire logic       wr_me = ce_i && cpu_req_i.wr && hit_bkpl &&
				(bkpl_idx == 5'(gi));
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					bkpl_code[gi]         <= `ADV_RESET;
					line                  <= '0;
					bkpl_serial_out_o[gi] <= 1'b0;
				end else if (ce_i) begin
					if (wr_me)
						bkpl_code[gi] <= cpu_req_i.wdata[`ADV_CODE_MSB:`ADV_CODE_LSB];
					line <= {line[DEPTH-1:0], bkpl_stream_i[gi]};
					bkpl_serial_out_o[gi] <= (tap == 3'd0) ? bkpl_stream_i[gi] :
						line[tap-3'd1];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_local0_write;
		ce_i && cpu_req_i.wr && cpu_req_i.addr == 8'h83;
	endsequence

	a_local_code_store: assert property (@(posedge clk_i) disable iff (rst_i)
		s_local0_write |=> local_code[0] == $past(cpu_req_i.wdata[1:0]))
		else $error("local register write lost");
	a_bkpl_code_store: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cpu_req_i.wr && cpu_req_i.addr == 8'hc2 |=>
		bkpl_code[31] == $past(cpu_req_i.wdata[1:0]))
		else $error("backplane register write lost");
	a_local_fast_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		local_fast_i |-> g_local[8].tap == 3'd6)
		else $error("local stream 8 advanced in fast mode");
	a_bkpl_fast_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		bkpl_fast_i |-> g_bkpl[16].tap == 3'd6)
		else $error("backplane stream 16 advanced in fast mode");
	a_slow_step_two: assert property (@(posedge clk_i) disable iff (rst_i)
		!local_fast_i && local_code[0] == 2'h3 |-> g_local[0].tap == 3'd0)
		else $error("slow code 3 not six cycles");
	a_fast_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
		local_fast_i && local_code[0] == 2'h1 |-> g_local[0].tap == 3'd5)
		else $error("fast code 1 not one cycle");
	a_zero_aligned: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && bkpl_code[0] == 2'h0) [*8] |->
		bkpl_serial_out_o[0] == $past(bkpl_stream_i[0], 7))
		else $error("code zero stream not aligned");
	a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cpu_req_i.rd && cpu_req_i.addr == 8'h83 |=>
		rd_ack_o && rdata_o == {14'h0000, $past(local_code[0])})
		else $error("read back wrong");
	a_own_stream: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cpu_req_i.wr && cpu_req_i.addr == 8'h84 |=> $stable(local_code[0]))
		else $error("write leaked to other stream");
endmodule

`default_nettype wire

/* File: sim/output_stream_advancement_test.sv */
// Self-checking bench for the output stream advancement register bank
// Assumes out_adv_pkg and out_adv_consts.svh are compiled ahead of it
`include "out_adv_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module output_stream_advancement_test;
	import out_adv_pkg::*;
	logic        clk_i = 0, rst_i = 1, ce_i = 1, frame_pulse_i = 0;
	logic        local_fast_i = 0, bkpl_fast_i = 0, rd_ack_o, output_frame_pulse_o;
	cpu_req_t    cpu_req_i = '0;
	logic [15:0] local_stream_i = '0, rdata_o, local_serial_out_o;
	logic [31:0] bkpl_stream_i = '0, bkpl_serial_out_o, seed = 32'h849214ed;
	logic [1:0]  lc [16];
	logic [1:0]  bc [32];
	logic [48:0] hist [64];
	int          mismatches = 0, n_checks = 0, cycles = 0;
	output_stream_advancement dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.cpu_req_i(cpu_req_i), .local_fast_i(local_fast_i), .bkpl_fast_i(bkpl_fast_i),
		.local_stream_i(local_stream_i), .bkpl_stream_i(bkpl_stream_i),
		.frame_pulse_i(frame_pulse_i), .rdata_o(rdata_o), .rd_ack_o(rd_ack_o),
		.local_serial_out_o(local_serial_out_o), .bkpl_serial_out_o(bkpl_serial_out_o),
		.output_frame_pulse_o(output_frame_pulse_o));
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] ra(input int i);
		return i < 16 ? 8'(`LOCAL_ADV_FIRST + i) : 8'(`BKPL_ADV_FIRST + i - 16);
	endfunction
	// Expected input-to-output latency; streams above the fast range keep code 0
	function automatic int dly(input logic [1:0] c, input logic fast, input logic on);
		return 7 - (on ? (fast ? int'(c) : 2 * int'(c)) : 0);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rw(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		#2;
		cpu_req_i = '{wr: wr, rd: ~wr, addr: a, wdata: d};
		@(posedge clk_i);
		#2;
		cpu_req_i = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rw(1'b0, a, 16'h0000);
		chk(32'(rd_ack_o), 32'h1);
		chk(32'(rdata_o), 32'(e));
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		#2;
		rst_i = 0;
		for (int i = 0; i < 48; i++) rd(ra(i), 16'h0000);
		foreach (hist[k]) hist[k] = '0;
		for (int k = 0; k < 4; k++) begin
			rw(1'b1, 8'h82 + 8'(k == 1 ? 17 : k == 2 ? 32 : k == 3 ? 65 : 0), 16'hffff);
			rd(8'h82 + 8'(k == 1 ? 17 : k == 2 ? 32 : k == 3 ? 65 : 0), 16'h0000);
		end
		$display("reset values and unmapped addresses done");
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 48; i++) begin
				seed = lfsr(seed);
				if (r == 0) seed[15:0] = 16'hffff;
				if (i < 16) lc[i] = seed[1:0];
				else bc[i - 16] = seed[1:0];
				rw(1'b1, ra(i), seed[15:0]);
			end
			for (int i = 0; i < 48; i++) rd(ra(i), {14'h0, i < 16 ? lc[i] : bc[i - 16]});
			local_fast_i = r[0];
			bkpl_fast_i = r[1];
			for (int t = 0; t < 60; t++) begin
				@(posedge clk_i);
				#1;
				if (t >= 10) begin
					chk(32'(output_frame_pulse_o), 32'(hist[t - 7][48]));
					for (int j = 0; j < 16; j++) chk(32'(local_serial_out_o[j]), 32'(hist[t - dly(lc[j], local_fast_i, !local_fast_i || j < 8)][j]));
					for (int j = 0; j < 32; j++) chk(32'(bkpl_serial_out_o[j]), 32'(hist[t - dly(bc[j], bkpl_fast_i, !bkpl_fast_i || j < 16)][16 + j]));
				end
				#1;
				seed = lfsr(seed);
				local_stream_i = seed[15:0];
				seed = lfsr(seed);
				bkpl_stream_i = seed;
				frame_pulse_i = (t % 16 == 0);
				hist[t] = {frame_pulse_i, bkpl_stream_i, local_stream_i};
			end
			$display("advance round %0d done", r);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
